//--- rtl/tcoc_pkg.sv
// Constants and state type for the timer counter and compare pin block
package tcoc_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_SELECT = 8'h00;
   localparam logic [7:0] ADDR_MASK7 = 8'h02;
   localparam logic [7:0] ADDR_DATA7 = 8'h03;
   localparam logic [7:0] ADDR_CNT_HI = 8'h04;
   localparam logic [7:0] ADDR_CNT_LO = 8'h05;
   localparam logic [7:0] ADDR_SYSCTL = 8'h06;
   localparam logic [7:0] ADDR_TOGGLE = 8'h07;
   localparam logic [7:0] ADDR_ACT_UP = 8'h08;
   localparam logic [7:0] ADDR_ACT_LO = 8'h09;
   localparam logic [7:0] ADDR_PRESCALE = 8'h0d;
   localparam logic [7:0] ADDR_CHAN_FIRST = 8'h10;
   localparam logic [7:0] ADDR_CHAN_LAST = 8'h1f;
   localparam logic [7:0] ADDR_ACC_HI = 8'h22;
   localparam logic [7:0] ADDR_ACC_LO = 8'h23;
   localparam int BIT_ON = 7;
   localparam int BIT_WAIT = 6;
   localparam int BIT_FRZ = 5;
   localparam int BIT_QCLR = 4;
   localparam logic [7:0] SYSCTL_MASK = 8'hf0;
   localparam logic [7:0] CHAN_MASK = 8'hfc;
   localparam logic [15:0] ACT_MASK = 16'hfff0;
   localparam int CH_LO = 2;
   localparam int CH_HI = 7;
   localparam int PRE_W = 7;
   localparam logic [5:0] DIV64_PHASE = 6'h3f;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   typedef enum logic [1:0] {TCOC_ACT_OFF, TCOC_ACT_TOGGLE, TCOC_ACT_LOW, TCOC_ACT_HIGH} tcoc_act_t;
   typedef struct packed {
      logic [7:0] select;
      logic [7:0] mask7;
      logic [7:0] data7;
      logic [7:0] toggle;
      logic [7:0] ctl;
      logic [15:0] action;
      logic [15:0] counter;
      logic [2:0] prescale;
      logic [PRE_W-1:0] pre;
      logic [7:0] rdData;
      logic tick;
      logic div64;
      logic ovf;
      logic ovfClr;
      logic accClr;
      logic accHalt;
      logic wakeOk;
      logic [7:2] chanClr;
      logic [7:2] pinVal;
      logic [7:2] pinOeB;
   } tcoc_state_t;
endpackage

//--- rtl/tcoc_timer.sv
// Timer main counter, prescaler, system control and compare pin actions
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
// What this block does
// - Channel 7 compare copies masked data to pins
// - Main counter is 16-bit up, two bytes
// - Counter writable only in test mode
// - First count after write may vary
// - Enable bit low stops timer and counter
// - No divide-by-64 clock while timer inactive
// - Halt-in-wait stops timer, accumulator, wakeup
// - Halt-in-freeze stops counter only
// - Quick clear on channel register access
// - Quick clear overflow flag on counter access
// - Quick clear accumulator flags on count access
// - Overflow toggles compare pins if enabled
// - Channel 7 override, then toggle, then force
// - Two-bit code: off, toggle, low, high
// - Nonzero code makes pin a compare output
// - Channel 7 pin follows mask bit 7 choice
// - Equal compares give channel 7 data priority
// - Prescaler divides by 1 to 128
module tcoc_timer
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [tcoc_pkg::ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   input wire logic testMode,
   input wire logic waitMode,
   input wire logic freezeMode,
   input wire logic [7:2] compareHit,
   input wire logic [7:2] forceAction,
   output logic [15:0] counterValue,
   output logic tickPulse,
   output logic div64Pulse,
   output logic overflowPulse,
   output logic ovfFlagClr,
   output logic accFlagClr,
   output logic [7:2] chanFlagClr,
   output logic accHalt,
   output logic wakeAllowed,
   output logic [7:2] pinOut,
   output logic [7:2] pinOeB
);
   import tcoc_pkg::*;

   tcoc_state_t st_ff;
   tcoc_state_t nxt_st;
   logic active;
   logic cntRun;
   logic tickNow;
   logic cntAdv;
   logic ovfNow;
   logic [PRE_W-1:0] divMask;
   logic [2:0] chIdx;
   logic chanAcc;
   logic [1:0] code;
   logic ownEv;
   logic overrideEv;
   logic togEv;

   always_comb
   begin
      nxt_st = st_ff;
      code = 2'b00;
      ownEv = 1'b0;
      overrideEv = 1'b0;
      togEv = 1'b0;
      // Freeze stops only the counter, so the prescaler keeps feeding the accumulator
      active = st_ff.ctl[BIT_ON] & ~(st_ff.ctl[BIT_WAIT] & waitMode);
      cntRun = active & ~(st_ff.ctl[BIT_FRZ] & freezeMode);
      divMask = PRE_W'((8'h01 << st_ff.prescale) - 8'h01);
      tickNow = active & ((st_ff.pre & divMask) == divMask);
      cntAdv = tickNow & cntRun;
      ovfNow = cntAdv & (st_ff.counter == CNT_MAX);
      chIdx = regAddr[3:1];
      chanAcc = (regAddr >= ADDR_CHAN_FIRST) && (regAddr <= ADDR_CHAN_LAST);

      // Prescaler restarts when the timer is off; a new divide applies from the next cycle
      nxt_st.pre = active ? PRE_W'(st_ff.pre + 7'h01) : '0;
      nxt_st.tick = tickNow;
      nxt_st.div64 = active & (st_ff.pre[5:0] == DIV64_PHASE);
      nxt_st.accHalt = st_ff.ctl[BIT_WAIT] & waitMode;
      nxt_st.wakeOk = ~(st_ff.ctl[BIT_WAIT] & waitMode);
      nxt_st.ovf = ovfNow;

      // Counter: test-mode write wins over the tick, prescaler phase is left alone
      if (cntAdv)
      begin
         nxt_st.counter = st_ff.counter + 16'h0001;
      end
      if (regWr && testMode && regAddr == ADDR_CNT_HI)
      begin
         nxt_st.counter[15:8] = regWrData;
      end
      if (regWr && testMode && regAddr == ADDR_CNT_LO)
      begin
         nxt_st.counter[7:0] = regWrData;
      end

      // Register writes
      if (regWr)
      begin
         unique case (regAddr)
            ADDR_SELECT: nxt_st.select = regWrData & CHAN_MASK;
            ADDR_MASK7: nxt_st.mask7 = regWrData & CHAN_MASK;
            ADDR_DATA7: nxt_st.data7 = regWrData & CHAN_MASK;
            ADDR_SYSCTL: nxt_st.ctl = regWrData & SYSCTL_MASK;
            ADDR_TOGGLE: nxt_st.toggle = regWrData & CHAN_MASK;
            ADDR_ACT_UP: nxt_st.action[15:8] = regWrData;
            ADDR_ACT_LO: nxt_st.action[7:0] = regWrData & ACT_MASK[7:0];
            ADDR_PRESCALE: nxt_st.prescale = regWrData[2:0];
            default: ;
         endcase
      end

      // Read data stand only in the cycle after the strobe
      nxt_st.rdData = RST_BYTE;
      if (regRd)
      begin
         unique case (regAddr)
            ADDR_SELECT: nxt_st.rdData = st_ff.select;
            ADDR_MASK7: nxt_st.rdData = st_ff.mask7;
            ADDR_DATA7: nxt_st.rdData = st_ff.data7;
            ADDR_CNT_HI: nxt_st.rdData = st_ff.counter[15:8];
            ADDR_CNT_LO: nxt_st.rdData = st_ff.counter[7:0];
            ADDR_SYSCTL: nxt_st.rdData = st_ff.ctl;
            ADDR_TOGGLE: nxt_st.rdData = st_ff.toggle;
            ADDR_ACT_UP: nxt_st.rdData = st_ff.action[15:8];
            ADDR_ACT_LO: nxt_st.rdData = st_ff.action[7:0];
            ADDR_PRESCALE: nxt_st.rdData = {5'h00, st_ff.prescale};
            default: nxt_st.rdData = RST_BYTE;
         endcase
      end

      // Quick flag clear strobes; unintended accesses clear flags too
      nxt_st.ovfClr = st_ff.ctl[BIT_QCLR] & (regRd | regWr)
         & (regAddr == ADDR_CNT_HI || regAddr == ADDR_CNT_LO);
      nxt_st.accClr = st_ff.ctl[BIT_QCLR] & (regRd | regWr)
         & (regAddr == ADDR_ACC_HI || regAddr == ADDR_ACC_LO);
      nxt_st.chanClr = '0;
      for (int i = CH_LO; i <= CH_HI; i++)
      begin
         if (st_ff.ctl[BIT_QCLR] && chanAcc && chIdx == 3'(i))
         begin
            nxt_st.chanClr[i] = (regRd & ~st_ff.select[i]) | (regWr & st_ff.select[i]);
         end
      end

      // Pin actions, channel 7 override first, then overflow toggle, then own compare
      for (int i = CH_LO; i <= CH_HI; i++)
      begin
         code = st_ff.action[2*i +: 2];
         overrideEv = compareHit[CH_HI] & st_ff.select[CH_HI] & st_ff.mask7[i];
         togEv = ovfNow & st_ff.toggle[i] & st_ff.select[i];
         ownEv = (compareHit[i] | forceAction[i]) & st_ff.select[i];
         if (overrideEv)
         begin
            nxt_st.pinVal[i] = st_ff.data7[i];
         end
         else if (togEv)
         begin
            nxt_st.pinVal[i] = ~st_ff.pinVal[i];
         end
         else if (ownEv)
         begin
            unique case (tcoc_act_t'(code))
               TCOC_ACT_OFF: nxt_st.pinVal[i] = st_ff.pinVal[i];
               TCOC_ACT_TOGGLE: nxt_st.pinVal[i] = ~st_ff.pinVal[i];
               TCOC_ACT_LOW: nxt_st.pinVal[i] = 1'b0;
               TCOC_ACT_HIGH: nxt_st.pinVal[i] = 1'b1;
            endcase
         end
         nxt_st.pinOeB[i] = ~(st_ff.select[i] & ((code != 2'b00) | st_ff.mask7[i]));
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_ff <= '{select: RST_BYTE, mask7: RST_BYTE, data7: RST_BYTE, toggle: RST_BYTE,
            ctl: RST_BYTE, action: RST_WORD, counter: RST_WORD, prescale: 3'h0,
            pre: '0, rdData: RST_BYTE, tick: 1'b0, div64: 1'b0, ovf: 1'b0,
            ovfClr: 1'b0, accClr: 1'b0, accHalt: 1'b0, wakeOk: 1'b1,
            chanClr: 6'h00, pinVal: 6'h00, pinOeB: 6'h3f};
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign regRdData = st_ff.rdData;
   assign counterValue = st_ff.counter;
   assign tickPulse = st_ff.tick;
   assign div64Pulse = st_ff.div64;
   assign overflowPulse = st_ff.ovf;
   assign ovfFlagClr = st_ff.ovfClr;
   assign accFlagClr = st_ff.accClr;
   assign chanFlagClr = st_ff.chanClr;
   assign accHalt = st_ff.accHalt;
   assign wakeAllowed = st_ff.wakeOk;
   assign pinOut = st_ff.pinVal;
   assign pinOeB = st_ff.pinOeB;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   logic cntWrite;
   assign cntWrite = regWr & testMode & (regAddr == ADDR_CNT_HI || regAddr == ADDR_CNT_LO);

   AST_CNT_STEP: assert property (cntAdv && !cntWrite |=> st_ff.counter == $past(st_ff.counter) + 16'h0001)
      else $error("counter did not step on tick");
   AST_CNT_WIDE: assert property (ovfNow && !cntWrite |=> st_ff.counter == 16'h0000 && overflowPulse)
      else $error("counter did not wrap with overflow");
   AST_CNT_RO: assert property (regWr && !testMode && !cntAdv |=> $stable(st_ff.counter))
      else $error("counter changed by write outside test mode");
   AST_CNT_TEST_WR: assert property (regWr && testMode && regAddr == ADDR_CNT_LO
      |=> st_ff.counter[7:0] == $past(regWrData))
      else $error("test mode counter write lost");
   AST_OFF_HOLD: assert property (!st_ff.ctl[BIT_ON] && !cntWrite |=> $stable(st_ff.counter))
      else $error("counter moved while timer disabled");
   AST_NO_DIV64: assert property (!active |=> !div64Pulse)
      else $error("divide-by-64 pulse while inactive");
   AST_WAIT_HALT: assert property (st_ff.ctl[BIT_WAIT] && waitMode
      |=> accHalt && !wakeAllowed && !div64Pulse && !tickPulse)
      else $error("timer not halted in wait");
   AST_FRZ: assert property (st_ff.ctl[BIT_FRZ] && freezeMode && !cntWrite |=> $stable(st_ff.counter))
      else $error("counter ran in freeze");
   AST_QCLR_CH: assert property (st_ff.ctl[BIT_QCLR] && regWr && regAddr == 8'h14 && st_ff.select[2]
      |=> chanFlagClr == 6'h01)
      else $error("channel 2 quick clear missing");
   AST_QCLR_OVF: assert property (st_ff.ctl[BIT_QCLR] && regRd && regAddr == ADDR_CNT_LO |=> ovfFlagClr)
      else $error("overflow quick clear missing");
   AST_QCLR_ACC: assert property (!st_ff.ctl[BIT_QCLR] |=> !accFlagClr && !ovfFlagClr)
      else $error("quick clear without enable");
   AST_OVF_TOG: assert property (ovfNow && st_ff.toggle[2] && st_ff.select[2]
      && !(compareHit[7] && st_ff.select[7] && st_ff.mask7[2]) |=> pinOut[2] != $past(pinOut[2]))
      else $error("overflow toggle missing on channel 2");
   AST_CH7_OVR: assert property (compareHit[7] && st_ff.select[7] && st_ff.mask7[3]
      |=> pinOut[3] == $past(st_ff.data7[3]))
      else $error("channel 7 data not copied");
   AST_SET_HIGH: assert property (compareHit[4] && st_ff.select[4] && st_ff.action[9:8] == 2'b11
      && !ovfNow && !(compareHit[7] && st_ff.select[7] && st_ff.mask7[4]) |=> pinOut[4])
      else $error("set high action missing");
   AST_DRIVE: assert property (st_ff.select[5] && st_ff.action[11:10] != 2'b00 && !regWr |=> !pinOeB[5])
      else $error("compare pin not driven");
   AST_DIV1: assert property (active && st_ff.prescale == 3'h0 |=> tickPulse)
      else $error("divide by one tick missing");

   // Counter, enable and prescaler; a stopped timer parks the prescaler so restarts are aligned
   AST_CNT_TEST_HI: assert property (regWr && testMode && regAddr == ADDR_CNT_HI
      |=> counterValue[15:8] == $past(regWrData))
      else $error("test mode high byte write lost");
   AST_CNT_IDLE: assert property (!cntAdv && !cntWrite
      |=> $stable(counterValue))
      else $error("counter moved without a tick");
   AST_CNT_FREE: assert property (tickNow && !st_ff.ctl[BIT_FRZ] && !cntWrite
      |=> counterValue == $past(counterValue) + 16'h0001)
      else $error("counter missed a tick");
   AST_OFF_NO_TICK: assert property (!st_ff.ctl[BIT_ON]
      |=> !tickPulse && !overflowPulse)
      else $error("tick or overflow while disabled");
   AST_OFF_PRE: assert property (!active
      |=> st_ff.pre == '0)
      else $error("prescaler not parked while inactive");
   AST_PRE_STEP: assert property (active
      |=> st_ff.pre == PRE_W'($past(st_ff.pre) + 7'h01))
      else $error("prescaler did not step");
   AST_DIV2: assert property (active && st_ff.prescale == 3'h1 && !st_ff.pre[0]
      |=> !tickPulse)
      else $error("divide by two ticked early");
   AST_DIV128: assert property (active && st_ff.prescale == 3'h7 && st_ff.pre != 7'h7f
      |=> !tickPulse)
      else $error("divide by 128 ticked early");
   AST_DIV128_TICK: assert property (active && st_ff.prescale == 3'h7 && st_ff.pre == 7'h7f
      |=> tickPulse)
      else $error("divide by 128 tick missing");

   // Accumulator clock and wait handling
   AST_DIV64_ON: assert property (active && st_ff.pre[5:0] == DIV64_PHASE
      |=> div64Pulse)
      else $error("divide-by-64 pulse missing");
   AST_DIV64_OFF: assert property (st_ff.pre[5:0] != DIV64_PHASE
      |=> !div64Pulse)
      else $error("divide-by-64 pulse out of phase");
   AST_FRZ_ACC: assert property (freezeMode && st_ff.ctl[BIT_FRZ] && active
      && st_ff.pre[5:0] == DIV64_PHASE
      |=> div64Pulse && !accHalt)
      else $error("accumulator clock stopped in freeze");
   AST_WAIT_FREE: assert property (!st_ff.ctl[BIT_WAIT] || !waitMode
      |=> !accHalt && wakeAllowed)
      else $error("halt without halt-in-wait");
   AST_WAIT_PRE: assert property (st_ff.ctl[BIT_WAIT] && waitMode && !cntWrite
      |=> st_ff.pre == '0 && $stable(counterValue))
      else $error("timer ran while halted in wait");

   // Quick clear pulses; any counter or accumulator access clears, channels by select, so stray accesses cost flags
   AST_QCLR_OVF_WR: assert property (st_ff.ctl[BIT_QCLR] && regWr && regAddr == ADDR_CNT_HI
      |=> ovfFlagClr)
      else $error("overflow clear on write missing");
   AST_QCLR_ACC_RD: assert property (st_ff.ctl[BIT_QCLR] && regRd && regAddr == ADDR_ACC_LO
      |=> accFlagClr)
      else $error("accumulator clear on read missing");
   AST_QCLR_ACC_WR: assert property (st_ff.ctl[BIT_QCLR] && regWr && regAddr == ADDR_ACC_HI
      |=> accFlagClr)
      else $error("accumulator clear on write missing");
   AST_QCLR_CAP_RD: assert property (st_ff.ctl[BIT_QCLR] && regRd && regAddr == 8'h16 && !st_ff.select[3]
      |=> chanFlagClr == 6'h02)
      else $error("capture read clear missing");
   AST_QCLR_IDLE: assert property (!regRd && !regWr
      |=> !ovfFlagClr && !accFlagClr && chanFlagClr == 6'h00)
      else $error("clear pulse without access");
   AST_QCLR_RANGE: assert property (!chanAcc
      |=> chanFlagClr == 6'h00)
      else $error("channel clear outside channel range");
   AST_QCLR_CH_OFF: assert property (!st_ff.ctl[BIT_QCLR]
      |=> chanFlagClr == 6'h00)
      else $error("channel clear without enable");
   AST_RD_CNT_HI: assert property (regRd && regAddr == ADDR_CNT_HI
      |=> regRdData == $past(counterValue[15:8]))
      else $error("counter high byte read wrong");
   AST_RD_CNT_LO: assert property (regRd && regAddr == ADDR_CNT_LO
      |=> regRdData == $past(counterValue[7:0]))
      else $error("counter low byte read wrong");

   // Pin priority: channel 7 override, then overflow toggle, then own compare or force
   AST_PIN_IDLE: assert property (!st_ff.select[6] && !st_ff.mask7[6]
      |=> $stable(pinOut[6]))
      else $error("capture channel pin changed");
   AST_TOG_FORCE: assert property (ovfNow && st_ff.toggle[3] && st_ff.select[3] && forceAction[3]
      && !(compareHit[7] && st_ff.select[7] && st_ff.mask7[3])
      |=> pinOut[3] != $past(pinOut[3]))
      else $error("toggle did not beat force");
   AST_OVR_TOG: assert property (compareHit[7] && st_ff.select[7] && st_ff.mask7[2]
      && ovfNow && st_ff.toggle[2]
      |=> pinOut[2] == $past(st_ff.data7[2]))
      else $error("override did not beat toggle");
   AST_SET_LOW: assert property (compareHit[5] && st_ff.select[5] && st_ff.action[11:10] == 2'b10
      && !ovfNow && !(compareHit[7] && st_ff.select[7] && st_ff.mask7[5])
      |=> !pinOut[5])
      else $error("clear low action missing");
   AST_ACT_TOG: assert property (compareHit[6] && st_ff.select[6] && st_ff.action[13:12] == 2'b01
      && !ovfNow && !(compareHit[7] && st_ff.select[7] && st_ff.mask7[6])
      |=> pinOut[6] != $past(pinOut[6]))
      else $error("toggle action missing");
   AST_ACT_OFF: assert property (compareHit[3] && st_ff.select[3] && st_ff.action[7:6] == 2'b00
      && !ovfNow && !(compareHit[7] && st_ff.select[7] && st_ff.mask7[3])
      |=> $stable(pinOut[3]))
      else $error("disconnected code moved pin");
   AST_UNDRIVEN: assert property (!st_ff.select[2]
      |=> pinOeB[2])
      else $error("capture channel pin driven");
   AST_IDLE_CODE: assert property (st_ff.action[5:4] == 2'b00 && !st_ff.mask7[2]
      |=> pinOeB[2])
      else $error("zero code pin driven");
   AST_CH7_OWN: assert property (compareHit[7] && st_ff.select[7] && !st_ff.mask7[7]
      && st_ff.action[15:14] == 2'b11 && !ovfNow
      |=> pinOut[7])
      else $error("channel 7 own action missing");
   AST_CH7_DATA: assert property (compareHit[7] && st_ff.select[7] && st_ff.mask7[7]
      |=> pinOut[7] == $past(st_ff.data7[7]))
      else $error("channel 7 data bit not applied");

   COV_OVERFLOW: cover property (overflowPulse);
   COV_OVERRIDE: cover property (compareHit[7] && st_ff.select[7] && st_ff.mask7[2]);
   COV_QCLR: cover property (ovfFlagClr);
   COV_DIV128: cover property (tickPulse && st_ff.prescale == 3'h7);
   COV_FORCE: cover property (forceAction[4] && st_ff.select[4]);
endmodule

//--- tb/tcoc_timer_test.sv
// Self-checking bench for the timer counter and compare pin block
`timescale 1ns/1ps
module tcoc_timer_test;
   import tcoc_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regRdData;
   logic testMode = 1'b0;
   logic waitMode = 1'b0;
   logic freezeMode = 1'b0;
   logic [7:2] compareHit = 6'h00;
   logic [7:2] forceAction = 6'h00;
   logic [15:0] counterValue;
   logic tickPulse, div64Pulse, overflowPulse, ovfFlagClr, accFlagClr, accHalt, wakeAllowed;
   logic [7:2] chanFlagClr, pinOut, pinOeB;
   logic [7:0] rdVal;
   logic [15:0] c0;
   int fail_count = 0;
   int samples_checked = 0;
   int n;
   logic [7:0] addrs [5] = '{8'h03, 8'h07, 8'h08, 8'h09, 8'h06};
   logic [7:0] masks [5] = '{8'hfc, 8'hfc, 8'hff, 8'hf0, 8'hf0};
   logic [1:0] codes [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
   logic pins [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
   always #10 clk = ~clk;
   tcoc_timer tcoc_timer_i (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .testMode(testMode), .waitMode(waitMode), .freezeMode(freezeMode),
      .compareHit(compareHit), .forceAction(forceAction), .counterValue(counterValue), .tickPulse(tickPulse),
      .div64Pulse(div64Pulse), .overflowPulse(overflowPulse), .ovfFlagClr(ovfFlagClr), .accFlagClr(accFlagClr),
      .chanFlagClr(chanFlagClr), .accHalt(accHalt), .wakeAllowed(wakeAllowed), .pinOut(pinOut), .pinOeB(pinOeB));
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Strobes drop for one cycle between accesses so no signal is assigned twice in a time step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(posedge clk);
      d = regRdData;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
      logic [7:0] d;
      rd(a, d);
      check({8'h00, d}, {8'h00, exp}, what);
   endtask
   task automatic hit(input logic [7:2] h, input logic [7:2] f);
      compareHit <= h;
      forceAction <= f;
      @(posedge clk);
      compareHit <= 6'h00;
      forceAction <= 6'h00;
      @(posedge clk);
   endtask
   task automatic run(input int cyc, output logic [15:0] delta, output int pulses);
      logic [15:0] s;
      pulses = 0;
      @(posedge clk);
      s = counterValue;
      repeat (cyc)
      begin
         @(posedge clk);
         pulses += int'(div64Pulse);
      end
      delta = counterValue - s;
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (40000) @(posedge clk);
      fail_count++;
      $display("[FAIL] %0t run did not finish in time", $time);
      print_verdict();
   end
   initial
   begin
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      check({15'h0, wakeAllowed}, 16'h1, "reset wake");
      check({10'h0, pinOeB}, 16'h3f, "reset enable");
      for (int i = 0; i < 5; i++)
      begin
         rdchk(addrs[i], 8'h00, "reset value");
         wr(addrs[i], 8'hff);
         rdchk(addrs[i], masks[i], "write mask");
         wr(addrs[i], 8'h00);
      end
      wr(8'h30, 8'hff);
      rdchk(8'h30, 8'h00, "unmapped");
      $display("test registers done");
      wr(ADDR_CNT_HI, 8'h12);
      rdchk(ADDR_CNT_HI, 8'h00, "counter write ignored");
      testMode <= 1'b1;
      wr(ADDR_CNT_HI, 8'hff);
      wr(ADDR_CNT_LO, 8'hfe);
      testMode <= 1'b0;
      // Timer is off here, so two byte reads still give one coherent word
      rdchk(ADDR_CNT_HI, 8'hff, "counter high");
      rdchk(ADDR_CNT_LO, 8'hfe, "counter low");
      wr(ADDR_SYSCTL, 8'h10);
      rd(ADDR_CNT_LO, rdVal);
      check({15'h0, ovfFlagClr}, 16'h1, "overflow clear");
      rd(ADDR_ACC_HI, rdVal);
      check({15'h0, accFlagClr}, 16'h1, "accumulator clear");
      wr(ADDR_SELECT, 8'h04);
      wr(8'h14, 8'h00);
      check({10'h0, chanFlagClr}, 16'h1, "channel clear on write");
      rd(8'h14, rdVal);
      check({10'h0, chanFlagClr}, 16'h0, "no clear on compare read");
      rd(8'h16, rdVal);
      check({10'h0, chanFlagClr}, 16'h2, "clear on capture read");
      wr(ADDR_SYSCTL, 8'h00);
      rd(ADDR_CNT_LO, rdVal);
      check({15'h0, ovfFlagClr}, 16'h0, "no clear when off");
      $display("test quick clear done");
      wr(ADDR_TOGGLE, 8'h04);
      wr(ADDR_SYSCTL, 8'h80);
      n = 0;
      while (overflowPulse !== 1'b1 && n < 40)
      begin
         @(posedge clk);
         n++;
      end
      check({15'h0, overflowPulse}, 16'h1, "overflow seen");
      repeat (2) @(posedge clk);
      check({15'h0, pinOut[2]}, 16'h1, "overflow toggle");
      wr(ADDR_SYSCTL, 8'h00);
      wr(ADDR_TOGGLE, 8'h00);
      for (int ps = 0; ps < 8; ps++)
      begin
         wr(ADDR_PRESCALE, 8'(ps));
         wr(ADDR_SYSCTL, 8'h80);
         run(128, c0, n);
         check(c0, 16'(128 >> ps), "prescaled steps");
         check(16'(n), 16'h2, "div64 running");
         wr(ADDR_SYSCTL, 8'h00);
      end
      run(128, c0, n);
      check(c0, 16'h0, "stopped counter");
      check(16'(n), 16'h0, "no div64 when off");
      $display("test counting done");
      wr(ADDR_PRESCALE, 8'h00);
      wr(ADDR_SYSCTL, 8'ha0);
      freezeMode <= 1'b1;
      run(20, c0, n);
      check(c0, 16'h0, "frozen counter");
      check({15'h0, tickPulse}, 16'h1, "prescaler runs in freeze");
      freezeMode <= 1'b0;
      run(20, c0, n);
      check(c0, 16'd20, "counter after freeze");
      wr(ADDR_SYSCTL, 8'hc0);
      waitMode <= 1'b1;
      run(70, c0, n);
      check(c0, 16'h0, "wait halt counter");
      check(16'(n), 16'h0, "wait halt div64");
      check({14'h0, accHalt, wakeAllowed}, 16'h2, "wait halt flags");
      wr(ADDR_SYSCTL, 8'h80);
      run(20, c0, n);
      check(c0, 16'd20, "wait without halt");
      check({14'h0, accHalt, wakeAllowed}, 16'h1, "wake allowed");
      waitMode <= 1'b0;
      wr(ADDR_SYSCTL, 8'h00);
      $display("test modes done");
      wr(ADDR_SELECT, 8'hfc);
      wr(ADDR_MASK7, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         wr(ADDR_ACT_LO, {codes[i], 6'h00});
         @(posedge clk);
         check({15'h0, pinOeB[3]}, {15'h0, codes[i] == 2'h0}, "pin enable");
         hit(6'h02, 6'h00);
         check({15'h0, pinOut[3]}, {15'h0, pins[i]}, "compare action");
      end
      wr(ADDR_ACT_UP, 8'h03);
      hit(6'h00, 6'h04);
      check({15'h0, pinOut[4]}, 16'h1, "forced action");
      wr(ADDR_MASK7, 8'h20);
      wr(ADDR_DATA7, 8'h20);
      wr(ADDR_ACT_UP, 8'h08);
      check({15'h0, pinOeB[5]}, 16'h0, "masked pin driven");
      hit(6'h28, 6'h00);
      check({15'h0, pinOut[5]}, 16'h1, "channel 7 data wins");
      hit(6'h08, 6'h00);
      check({15'h0, pinOut[5]}, 16'h0, "own action alone");
      wr(ADDR_MASK7, 8'ha0);
      wr(ADDR_DATA7, 8'h80);
      hit(6'h20, 6'h00);
      check({14'h0, pinOut[7], pinOeB[7]}, 16'h2, "channel 7 masked data");
      wr(ADDR_MASK7, 8'h00);
      wr(ADDR_ACT_UP, 8'h00);
      @(posedge clk);
      check({15'h0, pinOeB[7]}, 16'h1, "accumulator pin released");
      $display("test pins done");
      print_verdict();
   end
endmodule
